// *** hw/dsd_defs.svh ***
// Constants of the strobe delay margin block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef DSD_DEFS_SVH
`define DSD_DEFS_SVH
// Delay code magnitude width and delay line taps.
`define DSD_CODE_W 9
`define DSD_TAP_N 8
// Register byte offsets.
`define DSD_A_CTRL 8'h00
`define DSD_A_PRELOAD 8'h04
`define DSD_A_STATUS 8'h08
`define DSD_A_WCODE 8'h0C
`define DSD_A_RCODE 8'h10
`define DSD_A_STEP 8'h14
// Control register fields.
`define DSD_C_WEN 0
`define DSD_C_LEN 1
`define DSD_C_REN 2
`define DSD_C_RDIR 3
`define DSD_C_RLOADN 4
`define DSD_C_PAUSE 5
`define DSD_C_RMODE 6
`define DSD_C_WSIGN 7
`define DSD_C_RSIGN 8
`define DSD_C_RSEL 12
`define DSD_CTRL_RST 32'h0000_0000
// Preload fields, status bits, upper code field offset.
`define DSD_P_WMAG 0
`define DSD_P_RMAG 16
`define DSD_S_BURST 3
`define DSD_HI_CODE 16
// Channel and edge input indices.
`define DSD_CH_RD 0
`define DSD_CH_WR 1
`define DSD_CH_LV 2
`define DSD_E_WSTEP 0
`define DSD_E_LSTEP 1
`define DSD_E_ECLK 2
`define DSD_E_STRB 3
// Step pulse minimum width, owed by the core logic.
`define DSD_CLK_NS 10
`define DSD_STEP_MIN_NS 5
`define DSD_STEP_MIN_CYC ((`DSD_STEP_MIN_NS + `DSD_CLK_NS - 1) / `DSD_CLK_NS)
`endif

// *** hw/dsd_edge_sync.sv ***
// Two-flop synchroniser with rising edge detect for one pin.
// Assumes the pin is asynchronous to hclk.
`timescale 1ns/10ps
`default_nettype none
module dsd_edge_sync (
  // Clock and control.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Pin and results.
  input wire logic pin,
  output logic lvl_reg,
  output logic rise
);
  logic s1_reg;
  logic dly_reg;

  // The first flop feeds only the second, to contain metastability.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= 1'b0;
      lvl_reg <= 1'b0;
      dly_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= pin;
      lvl_reg <= s1_reg;
      dly_reg <= lvl_reg;
    end
  end

  // One pulse per rising edge, however long the pin stays high.
  assign rise = lvl_reg & ~dly_reg;
endmodule
`default_nettype wire

// *** hw/dsd_margin_counter.sv ***
// Signed margin delay counter with preload, clear and limit flag.
// Assumes move is a one-cycle event already aligned to the edge clock.
`timescale 1ns/10ps
`default_nettype none
`include "dsd_defs.svh"
module dsd_margin_counter #(
  parameter int W = `DSD_CODE_W,
  parameter bit LOAD_CLEARS = 1'b0
) (
  // Clock and control.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic clr,
  input wire dsd_pkg::dsd_chan_ctl_t ctl,
  // Results.
  output logic [W:0] code_reg,
  output logic flag_reg
);
  logic at_lim;
  logic step_ok;

  // Saturate instead of wrapping, so a flagged code stays usable.
  assign at_lim = ctl.dir ? (code_reg == {1'b1, {W{1'b0}}}) : (code_reg == {1'b0, {W{1'b1}}});
  assign step_ok = ctl.load_n & ctl.enable & ctl.move;

  // Code update: clear, preload or step.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_reg <= '0;
    end else if (ce) begin
      if (clr) begin
        code_reg <= '0;
      end else if (!ctl.load_n) begin
        if (LOAD_CLEARS) begin
          code_reg <= '0;
        end else if (ctl.enable && ctl.move) begin
          code_reg <= {ctl.sign, ctl.mag};
        end
      end else if (step_ok && !at_lim) begin
        code_reg <= ctl.dir ? code_reg - (W+1)'(1) : code_reg + (W+1)'(1);
      end
    end
  end

  // Limit flag, one cycle per refused step.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 1'b0;
    end else if (ce) begin
      flag_reg <= step_ok & at_lim & ~clr;
    end
  end
endmodule
`default_nettype wire

// *** hw/dsd_pkg.sv ***
// Types shared by the strobe delay margin block.
// Assumes dsd_defs.svh is on the include path.
`include "dsd_defs.svh"
package dsd_pkg;
  // Per-channel counter control bundle.
  typedef struct packed {
    logic move;
    logic dir;
    logic load_n;
    logic enable;
    logic sign;
    logic [`DSD_CODE_W-1:0] mag;
  } dsd_chan_ctl_t;
  // Bus data phase state.
  typedef enum logic [0:0] {DSD_IDLE, DSD_WDATA} dsd_bus_t;
endpackage

// *** hw/dsd_top.sv ***
// Strobe delay and margin control: write and leveling counters, shifted
// clocks, burst detect and FIFO pointers, with an AHB-Lite register port.
// Assumes one master on the bus and pins asynchronous to hclk.
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "dsd_defs.svh"
module dsd_top #(
  parameter int TAPS = `DSD_TAP_N
) (
  // Clock, reset, enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Margin control pins from core logic.
  input wire logic write_step_pulse,
  input wire logic write_count_direction,
  input wire logic write_delay_load_n,
  input wire logic leveling_step_pulse,
  input wire logic leveling_count_direction,
  input wire logic leveling_load_n,
  input wire logic smoothing_counter_reset,
  // Clocks, code and strobe.
  input wire logic edge_clock_input,
  input wire logic [`DSD_CODE_W-1:0] master_delay_code,
  input wire logic strobe_input,
  // Flags and pointers.
  output logic read_burst_flag,
  output logic burst_flag_sys,
  output logic read_valid_flag,
  output logic [2:0] fifo_read_pointer,
  output logic [2:0] fifo_write_pointer,
  output logic read_margin_flag,
  output logic write_margin_flag,
  output logic leveling_margin_flag,
  // Shifted clocks.
  output logic read_strobe_quarter_shift,
  output logic write_clock_three_quarter_shift,
  output logic write_strobe_clock,
  output logic read_training_clock
);
  localparam int CW = `DSD_CODE_W;
  localparam int LW = CW + 5;
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] e_raw;
  logic [3:0] e_lvl;
  logic [3:0] e_rise;
  logic [LW-1:0] lv_s1_reg;
  logic [LW-1:0] lv_s2_reg;
  logic wdir_s;
  logic wload_n_s;
  logic ldir_s;
  logic lload_n_s;
  logic [CW-1:0] mcode_s;
  logic smooth_s;

  assign e_raw = {strobe_input, edge_clock_input, leveling_step_pulse, write_step_pulse};

  // Edge-sensitive pins each get a synchroniser with edge detect.
  for (genvar g = 0; g < 4; g++) begin : g_edge
    dsd_edge_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .pin(e_raw[g]),
      .lvl_reg(e_lvl[g]),
      .rise(e_rise[g])
    );
  end

  // Level pins; the master code is quasi-static, so bitwise sync is safe.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lv_s1_reg <= '0;
      lv_s2_reg <= '0;
    end else if (ce) begin
      lv_s1_reg <= {smoothing_counter_reset, master_delay_code, leveling_count_direction,
                    leveling_load_n, write_count_direction, write_delay_load_n};
      lv_s2_reg <= lv_s1_reg;
    end
  end
  assign {smooth_s, mcode_s, ldir_s, lload_n_s, wdir_s, wload_n_s} = lv_s2_reg;

  // ----------------------------------------------------------------
  // Register file and AHB-Lite slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] preload_reg;
  logic [2:0] sticky_reg;
  logic rstep_reg;
  logic [7:0] dp_addr_reg;
  dsd_pkg::dsd_bus_t state_reg;
  logic ap;
  logic wr_dp;
  logic [CW:0] ch_code [3];
  logic [2:0] ch_flag;

  // Word-only transfers are taken; other sizes are ignored.
  assign ap = hsel & hready & htrans[1] & (hsize == 3'h2) & ce;
  assign wr_dp = (state_reg == dsd_pkg::DSD_WDATA) & ce;
  // Frozen block inserts wait states rather than drop a transfer.
  assign hreadyout = ce;
  assign hresp = 1'b0;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `DSD_A_CTRL: rd_mux = ctrl_reg;
      `DSD_A_PRELOAD: rd_mux = preload_reg;
      `DSD_A_STATUS: rd_mux = {28'h0000000, burst_flag_sys, sticky_reg};
      `DSD_A_WCODE: rd_mux = {6'h00, ch_code[`DSD_CH_LV], 6'h00, ch_code[`DSD_CH_WR]};
      `DSD_A_RCODE: rd_mux = {7'h00, mcode_s, 6'h00, ch_code[`DSD_CH_RD]};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // Address phase: latch write target, sample read data for the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= dsd_pkg::DSD_IDLE;
      dp_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      case (state_reg)
        dsd_pkg::DSD_IDLE, dsd_pkg::DSD_WDATA: begin
          state_reg <= (ap && hwrite) ? dsd_pkg::DSD_WDATA : dsd_pkg::DSD_IDLE;
        end
        default: state_reg <= dsd_pkg::DSD_IDLE;
      endcase
      if (ap) begin
        dp_addr_reg <= haddr[7:0];
      end
      if (ap && !hwrite) begin
        hrdata <= rd_mux(haddr[7:0]);
      end
    end
  end

  // Control and preload registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `DSD_CTRL_RST;
      preload_reg <= 32'h0000_0000;
    end else if (wr_dp) begin
      if (dp_addr_reg == `DSD_A_CTRL) begin
        ctrl_reg <= hwdata;
      end
      if (dp_addr_reg == `DSD_A_PRELOAD) begin
        preload_reg <= hwdata;
      end
    end
  end

  // Read-side step is a register strobe, one cycle long.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rstep_reg <= 1'b0;
    end else if (ce) begin
      rstep_reg <= wr_dp & (dp_addr_reg == `DSD_A_STEP) & hwdata[0];
    end
  end

  // Sticky margin flags: write one clears, a new flag in that cycle wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sticky_reg <= 3'h0;
    end else if (ce) begin
      sticky_reg <= (sticky_reg & ~((wr_dp && dp_addr_reg == `DSD_A_STATUS) ? hwdata[2:0] : 3'h0))
                    | ch_flag;
    end
  end

  // ----------------------------------------------------------------
  // Move events and margin counters
  // ----------------------------------------------------------------
  logic pause;
  logic eclk_fire;
  logic [2:0] step_rise;
  logic [2:0] pend_reg;
  logic [2:0] move;
  dsd_pkg::dsd_chan_ctl_t ctl [3];

  assign pause = ctrl_reg[`DSD_C_PAUSE];
  // Edge clock from one tree; pause freezes its moves.
  assign eclk_fire = e_rise[`DSD_E_ECLK] & ~pause;
  assign step_rise = {e_rise[`DSD_E_LSTEP], e_rise[`DSD_E_WSTEP], rstep_reg};
  assign move = pend_reg & {3{eclk_fire}};

  // A step waits for the next edge clock rise; a new step in that cycle stays pending.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= 3'h0;
    end else if (ce) begin
      pend_reg <= (pend_reg & ~move) | step_rise;
    end
  end

  // Channel controls.
  always_comb begin
    ctl[`DSD_CH_RD] = {move[`DSD_CH_RD], ctrl_reg[`DSD_C_RDIR], ctrl_reg[`DSD_C_RLOADN],
                       ctrl_reg[`DSD_C_REN], ctrl_reg[`DSD_C_RSIGN], preload_reg[`DSD_P_RMAG +: CW]};
    ctl[`DSD_CH_WR] = {move[`DSD_CH_WR], wdir_s, wload_n_s, ctrl_reg[`DSD_C_WEN],
                       ctrl_reg[`DSD_C_WSIGN], preload_reg[`DSD_P_WMAG +: CW]};
    ctl[`DSD_CH_LV] = {move[`DSD_CH_LV], ldir_s, lload_n_s, ctrl_reg[`DSD_C_LEN],
                       1'b0, {CW{1'b0}}};
  end

  // Read and write counters preload; the leveling counter clears while loading.
  for (genvar c = 0; c < 3; c++) begin : g_ch
    dsd_margin_counter #(
      .W(CW),
      .LOAD_CLEARS(c == `DSD_CH_LV)
    ) u_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .clr(smooth_s),
      .ctl(ctl[c]),
      .code_reg(ch_code[c]),
      .flag_reg(ch_flag[c])
    );
  end
  assign read_margin_flag = ch_flag[`DSD_CH_RD];
  assign write_margin_flag = ch_flag[`DSD_CH_WR];
  assign leveling_margin_flag = ch_flag[`DSD_CH_LV];

  // ----------------------------------------------------------------
  // Delay lines and shifted clocks
  // ----------------------------------------------------------------
  logic [TAPS-1:0] eline_reg;
  logic [TAPS-1:0] sline_reg;
  logic [2:0] qtap;
  logic [2:0] rtap;
  logic [2:0] wtap;
  logic [3:0] rsel;

  function automatic logic pick(input logic [TAPS-1:0] line, input logic [2:0] idx);
    pick = line[idx];
  endfunction

  // The master code sets a quarter period; margin codes trim around it.
  assign qtap = mcode_s[4:2];
  assign rtap = qtap + ch_code[`DSD_CH_RD][2:0];
  assign wtap = 3'(qtap * 3'h3) + ch_code[`DSD_CH_WR][2:0];
  assign rsel = ctrl_reg[`DSD_C_RSEL +: 4];

  // Sampled delay lines; resolution is one hclk, coarse by nature.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eline_reg <= '0;
      sline_reg <= '0;
    end else if (ce) begin
      eline_reg <= {eline_reg[TAPS-2:0], e_lvl[`DSD_E_ECLK]};
      sline_reg <= {sline_reg[TAPS-2:0], e_lvl[`DSD_E_STRB]};
    end
  end

  // Tapped clock outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_strobe_quarter_shift <= 1'b0;
      write_clock_three_quarter_shift <= 1'b0;
      write_strobe_clock <= 1'b0;
      read_training_clock <= 1'b0;
    end else if (ce) begin
      read_strobe_quarter_shift <= pick(sline_reg, rtap);
      write_clock_three_quarter_shift <= pick(eline_reg, wtap);
      write_strobe_clock <= pick(eline_reg, ch_code[`DSD_CH_LV][2:0]);
      read_training_clock <= pick(eline_reg, rsel[2:0]) ^ rsel[3];
    end
  end

  // ----------------------------------------------------------------
  // Burst detect, data valid, FIFO pointers
  // ----------------------------------------------------------------
  logic rmode;
  logic strobe_rise;
  logic fifo_has;

  assign rmode = ctrl_reg[`DSD_C_RMODE];
  assign strobe_rise = e_rise[`DSD_E_STRB] & rmode;
  assign fifo_has = fifo_read_pointer != fifo_write_pointer;

  // Burst pulse per strobe edge; system flag holds until read mode ends.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_burst_flag <= 1'b0;
      burst_flag_sys <= 1'b0;
    end else if (ce) begin
      read_burst_flag <= strobe_rise;
      burst_flag_sys <= rmode & (burst_flag_sys | read_burst_flag);
    end
  end

  // Pointers reset outside read mode so each read mode period starts aligned; bursts within it do not realign them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_write_pointer <= 3'h0;
      fifo_read_pointer <= 3'h0;
      read_valid_flag <= 1'b0;
    end else if (ce) begin
      if (!rmode) begin
        fifo_write_pointer <= 3'h0;
        fifo_read_pointer <= 3'h0;
        read_valid_flag <= 1'b0;
      end else begin
        fifo_write_pointer <= fifo_write_pointer + {2'h0, strobe_rise};
        fifo_read_pointer <= fifo_read_pointer + {2'h0, e_rise[`DSD_E_ECLK] & fifo_has};
        read_valid_flag <= e_rise[`DSD_E_ECLK] & fifo_has;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_wr_preload: assert property (ce && !wload_n_s && ctl[1].enable && move[1] && !smooth_s |=>
    ch_code[1] == $past({ctl[1].sign, ctl[1].mag})) else $error("write preload missed");
  a_wr_count_up: assert property (ce && wload_n_s && ctl[1].enable && move[1] && !wdir_s &&
    !smooth_s && ch_code[1] != 10'h1FF |=> ch_code[1] == $past(ch_code[1]) + 10'h001)
    else $error("write up step wrong");
  a_lv_count_down: assert property (ce && lload_n_s && ctl[2].enable && move[2] && ldir_s &&
    !smooth_s && ch_code[2] != 10'h200 |=> ch_code[2] == $past(ch_code[2]) - 10'h001)
    else $error("leveling down step wrong");
  a_lv_held_clr: assert property (ce && !lload_n_s |=> ch_code[2] == 10'h000)
    else $error("leveling not cleared");
  a_move_single: assert property (ce && move[1] |=> !move[1])
    else $error("double write move");
  a_step_to_move: assert property (ce && e_rise[0] ##1 eclk_fire |-> move[1])
    else $error("step not moved");
  a_pause_stops: assert property (pause |-> move == 3'h0)
    else $error("move while paused");
  a_smooth_clear: assert property (ce && smooth_s |=> ch_code[0] == 10'h000 && ch_code[1] == 10'h000 &&
    ch_code[2] == 10'h000) else $error("smoothing reset ignored");
  a_flag_sticky: assert property (ce && write_margin_flag |=> sticky_reg[1])
    else $error("write flag lost");
  a_burst_sys: assert property (ce && read_burst_flag && rmode ##1 ce && rmode |-> burst_flag_sys)
    else $error("burst not raised");

  c_wr_preload: cover property (!wload_n_s && move[1] && ctl[1].enable);
  c_lv_step: cover property (lload_n_s && move[2] && ctl[2].enable);
  c_burst_valid: cover property (burst_flag_sys ##[1:20] read_valid_flag);
  c_flag_limit: cover property (write_margin_flag);
endmodule
`default_nettype wire

// *** verification/dsd_core_model.sv ***
// Core-side calibration logic model: free edge clock and step pulse makers.
// Assumes one-cycle step requests from the bench on hclk.
`timescale 1ns/10ps
`default_nettype none
module dsd_core_model (
  // Clock and requests.
  input wire logic hclk,
  input wire logic wreq,
  input wire logic lreq,
  input wire logic [3:0] width,
  // Pins toward the delay block.
  output wire logic write_step_pulse,
  output wire logic leveling_step_pulse,
  output var logic edge_clock_input
);
  // ----------------------------------------
  // Edge clock and pulse stretchers
  // ----------------------------------------
  logic [3:0] wcnt_reg = 4'h0;
  logic [3:0] lcnt_reg = 4'h0;

  // The edge tree runs free, unrelated in phase to hclk.
  initial begin
    edge_clock_input = 1'b0;
    forever #13 edge_clock_input = ~edge_clock_input;
  end

  // A zero width is widened to one cycle, as a pulse shorter than that is lost.
  always @(posedge hclk) begin
    if (wreq) wcnt_reg <= (width == 4'h0) ? 4'h1 : width;
    else if (wcnt_reg != 4'h0) wcnt_reg <= wcnt_reg - 4'h1;
    if (lreq) lcnt_reg <= (width == 4'h0) ? 4'h1 : width;
    else if (lcnt_reg != 4'h0) lcnt_reg <= lcnt_reg - 4'h1;
  end

  // Pulses stay high for whole hclk cycles, ten nanoseconds at least.
  assign write_step_pulse = (wcnt_reg != 4'h0);
  assign leveling_step_pulse = (lcnt_reg != 4'h0);
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the strobe delay margin block.
// Assumes dsd_pkg and dsd_defs.svh are compiled and on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "dsd_defs.svh"
module tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic hclk, hresetn, hsel, hwrite, wreq, lreq, smrst, wdir, wload_n, ldir, lload_n, strb, rsq_q;
  logic [1:0] htrans;
  logic [3:0] width;
  logic [8:0] mcode;
  logic [31:0] haddr, hwdata, q;
  wire logic [31:0] hrdata;
  wire logic hreadyout, wsp, lsp, eclk, wflag, rvalid, rburst, rsq;
  wire logic [2:0] rptr, wptr;
  int mismatches, tests_run, wflags, base, rvalids, bursts, rsqs;

  dsd_core_model dsd_core_model_i (.hclk(hclk), .wreq(wreq), .lreq(lreq), .width(width),
    .write_step_pulse(wsp), .leveling_step_pulse(lsp), .edge_clock_input(eclk));
  dsd_top #(.TAPS(8)) dsd_top_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(), .hrdata(hrdata), .write_step_pulse(wsp), .write_count_direction(wdir), .write_delay_load_n(wload_n),
    .leveling_step_pulse(lsp), .leveling_count_direction(ldir), .leveling_load_n(lload_n),
    .smoothing_counter_reset(smrst), .edge_clock_input(eclk), .master_delay_code(mcode), .strobe_input(strb),
    .read_burst_flag(rburst), .burst_flag_sys(), .read_valid_flag(rvalid), .fifo_read_pointer(rptr),
    .fifo_write_pointer(wptr), .read_margin_flag(), .write_margin_flag(wflag), .leveling_margin_flag(),
    .read_strobe_quarter_shift(rsq),
    .write_clock_three_quarter_shift(), .write_strobe_clock(), .read_training_clock());

  // Clock at 100 MHz.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Flag pulses last one cycle, so they are counted rather than sampled later.
  always @(posedge hclk) begin
    if (wflag === 1'b1) wflags <= wflags + 1;
    if (rvalid === 1'b1) rvalids <= rvalids + 1;
    if (rburst === 1'b1) bursts <= bursts + 1;
    if (rsq === 1'b1 && rsq_q === 1'b0) rsqs <= rsqs + 1;
    rsq_q <= rsq;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches.", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for hready at a rising edge, with a bound that ends the run.
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        mismatches++;
        report_and_stop();
      end
      @(posedge hclk);
    end
  endtask

  // One single word transfer; entered just after a rising edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  // Polls until the value shows, then reads again later so a second move is caught.
  task automatic expect_reg(input logic [31:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    bus(1'b0, a, 32'h0);
    while (q !== exp && n < 50) begin
      n++;
      bus(1'b0, a, 32'h0);
    end
    repeat (40) @(posedge hclk);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic step(input logic lev, input logic [3:0] w);
    wreq <= ~lev;
    lreq <= lev;
    width <= w;
    @(posedge hclk);
    wreq <= 1'b0;
    lreq <= 1'b0;
    repeat (w + 2) @(posedge hclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    expect_reg(`DSD_A_WCODE, 32'h0);
    bus(1'b0, 32'h18, 32'h0);
    chk(q, 32'h0);
  endtask

  // Preload, then a long pulse up and a short pulse down.
  task automatic t_write();
    bus(1'b1, `DSD_A_CTRL, 32'h1);
    bus(1'b1, `DSD_A_PRELOAD, 32'h5);
    wload_n <= 1'b0;
    step(1'b0, 4'h1);
    expect_reg(`DSD_A_WCODE, 32'h5);
    wload_n <= 1'b1;
    wdir <= 1'b0;
    step(1'b0, 4'h9);
    expect_reg(`DSD_A_WCODE, 32'h6);
    wdir <= 1'b1;
    step(1'b0, 4'h1);
    expect_reg(`DSD_A_WCODE, 32'h5);
  endtask

  // A step under pause stays pending and runs once pause drops.
  task automatic t_pause();
    bus(1'b1, `DSD_A_CTRL, 32'h21);
    wdir <= 1'b0;
    step(1'b0, 4'h1);
    expect_reg(`DSD_A_WCODE, 32'h5);
    bus(1'b1, `DSD_A_CTRL, 32'h1);
    expect_reg(`DSD_A_WCODE, 32'h6);
  endtask

  task automatic t_level();
    bus(1'b1, `DSD_A_CTRL, 32'h3);
    lload_n <= 1'b1;
    ldir <= 1'b0;
    step(1'b1, 4'h1);
    expect_reg(`DSD_A_WCODE, 32'h0001_0006);
    step(1'b1, 4'h1);
    expect_reg(`DSD_A_WCODE, 32'h0002_0006);
    ldir <= 1'b1;
    step(1'b1, 4'h1);
    expect_reg(`DSD_A_WCODE, 32'h0001_0006);
    lload_n <= 1'b0;
    expect_reg(`DSD_A_WCODE, 32'h6);
  endtask

  // Stepping past the top holds the code and pulses the write flag once.
  task automatic t_limit();
    bus(1'b1, `DSD_A_PRELOAD, 32'h1FF);
    wload_n <= 1'b0;
    step(1'b0, 4'h1);
    expect_reg(`DSD_A_WCODE, 32'h1FF);
    wload_n <= 1'b1;
    wdir <= 1'b0;
    base = wflags;
    step(1'b0, 4'h1);
    expect_reg(`DSD_A_WCODE, 32'h1FF);
    chk(32'(wflags - base), 32'h1);
    expect_reg(`DSD_A_STATUS, 32'h2);
  endtask

  task automatic t_clear();
    smrst <= 1'b1;
    repeat (5) @(posedge hclk);
    smrst <= 1'b0;
    expect_reg(`DSD_A_WCODE, 32'h0);
    mcode <= 9'h0A5;
    expect_reg(`DSD_A_RCODE, 32'h00A5_0000);
  endtask

  // Read channel through the step register: preload, then one count up.
  task automatic t_rstep();
    bus(1'b1, `DSD_A_PRELOAD, 32'h0003_0000);
    bus(1'b1, `DSD_A_CTRL, 32'h4);
    bus(1'b1, `DSD_A_STEP, 32'h1);
    expect_reg(`DSD_A_RCODE, 32'h00A5_0003);
    bus(1'b1, `DSD_A_CTRL, 32'h14);
    bus(1'b1, `DSD_A_STEP, 32'h1);
    expect_reg(`DSD_A_RCODE, 32'h00A5_0004);
  endtask

  // Three strobe bursts in read mode; each one must show once on the pointers, the valid and burst pulses and the quarter-shift strobe.
  task automatic t_read();
    bus(1'b1, `DSD_A_CTRL, 32'h43);
    repeat (3) begin
      strb <= 1'b1;
      repeat (4) @(posedge hclk);
      strb <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    repeat (20) @(posedge hclk);
    chk(32'(wptr), 32'h3);
    chk(32'(rptr), 32'h3);
    chk(32'(rvalids), 32'h3);
    chk(32'(bursts), 32'h3);
    chk(32'(rsqs), 32'h3);
    expect_reg(`DSD_A_STATUS, 32'hA);
    bus(1'b1, `DSD_A_STATUS, 32'h7);
    expect_reg(`DSD_A_STATUS, 32'h8);
    bus(1'b1, `DSD_A_CTRL, 32'h3);
    expect_reg(`DSD_A_STATUS, 32'h0);
    chk(32'(wptr), 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    wreq = 1'b0;
    lreq = 1'b0;
    width = 4'h1;
    wdir = 1'b0;
    wload_n = 1'b1;
    ldir = 1'b0;
    lload_n = 1'b0;
    smrst = 1'b0;
    strb = 1'b0;
    mcode = 9'h000;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_write();
    t_pause();
    t_level();
    t_limit();
    t_clear();
    t_rstep();
    t_read();
    report_and_stop();
  end
endmodule
`default_nettype wire
